// ==== inc/exu_consts.svh ====
// constants of the exception entry/exit unit
`ifndef EXU_CONSTS_SVH
`define EXU_CONSTS_SVH
// ----------------------------------------
// mode encodings of status bits [4:0]
// ----------------------------------------
`define EXU_MODE_USR 5'h10
`define EXU_MODE_FIQ 5'h11
`define EXU_MODE_IRQ 5'h12
`define EXU_MODE_SVC 5'h13
`define EXU_MODE_ABT 5'h17
`define EXU_MODE_UND 5'h1B
`define EXU_MODE_SYS 5'h1F
// ----------------------------------------
// status word field positions
// ----------------------------------------
`define EXU_PSR_T 5
`define EXU_PSR_F 6
`define EXU_PSR_I 7
// undefined bits come up as zero
`define EXU_PSR_RST 32'h000000D3
// ----------------------------------------
// vector bases and offsets
// ----------------------------------------
`define EXU_VEC_LO 32'h00000000
`define EXU_VEC_HI 32'hFFFF0000
`define EXU_OFS_RST 32'h00000000
`define EXU_OFS_UND 32'h00000004
`define EXU_OFS_TRAP 32'h00000008
`define EXU_OFS_PFA 32'h0000000C
`define EXU_OFS_DFA 32'h00000010
`define EXU_OFS_IRQ 32'h00000018
`define EXU_OFS_FIQ 32'h0000001C
// ----------------------------------------
// link offsets
// ----------------------------------------
`define EXU_LINK_2 32'h00000002
`define EXU_LINK_4 32'h00000004
`define EXU_LINK_8 32'h00000008
// bank index meaning "no saved status word"
`define EXU_BANK_NONE 3'h5
`endif

// ==== inc/exu_pkg.sv ====
// types and helpers of the exception entry/exit unit
package exu_pkg;
`include "exu_consts.svh"

  typedef enum logic [1:0] {
    EXU_ST_RST = 2'h0,
    EXU_ST_RUN = 2'h3,
    EXU_ST_ENT = 2'h1
  } exu_state_t;

  typedef enum logic [2:0] {
    EXU_K_NONE = 3'h0,
    EXU_K_RST  = 3'h1,
    EXU_K_UND  = 3'h2,
    EXU_K_TRAP = 3'h3,
    EXU_K_PFA  = 3'h4,
    EXU_K_DFA  = 3'h5,
    EXU_K_IRQ  = 3'h6,
    EXU_K_FIQ  = 3'h7
  } exu_kind_t;

  typedef struct packed {
    exu_state_t        st;
    logic [31:0]       stat;
    logic [4:0][31:0]  saved;
    logic              fabt;
    logic              eabt;
    logic              dfa_pend;
    logic              ent;
    logic              lwr;
    logic [31:0]       link;
    logic [2:0]        lbank;
    logic [31:0]       vec;
    exu_kind_t         kind;
    logic              brst;
    logic [3:0]        breg;
    logic [31:0]       bval;
    logic              abandon;
  } exu_regs_t;

  // banked saved status word per mode
  function automatic logic [2:0] exu_bank(input logic [4:0] mode);
    case (mode)
      `EXU_MODE_FIQ: exu_bank = 3'h0;
      `EXU_MODE_IRQ: exu_bank = 3'h1;
      `EXU_MODE_SVC: exu_bank = 3'h2;
      `EXU_MODE_ABT: exu_bank = 3'h3;
      `EXU_MODE_UND: exu_bank = 3'h4;
      default:       exu_bank = `EXU_BANK_NONE;
    endcase
  endfunction

  function automatic logic [4:0] exu_kind_mode(input exu_kind_t k);
    case (k)
      EXU_K_FIQ:  exu_kind_mode = `EXU_MODE_FIQ;
      EXU_K_IRQ:  exu_kind_mode = `EXU_MODE_IRQ;
      EXU_K_PFA:  exu_kind_mode = `EXU_MODE_ABT;
      EXU_K_DFA:  exu_kind_mode = `EXU_MODE_ABT;
      EXU_K_UND:  exu_kind_mode = `EXU_MODE_UND;
      default:    exu_kind_mode = `EXU_MODE_SVC;
    endcase
  endfunction
endpackage

// ==== rtl/exu_core.sv ====
// exception entry and exit sequencing of the core
//
// Function
// - full-width entry links next instruction: address plus 4 or 8
// - compact entry links address plus per-exception offset
// - trap and undefined: link plus 4 full-width, plus 2 compact
// - data abort: link is aborting instruction address plus 8
// - interrupts, prefetch abort, breakpoint: link is address plus 4
// - entry copies status word into the target mode's saved copy
// - entry forces mode field and redirects fetch to the vector
// - handlers always run in full-width state
// - status-update write to r15 restores saved status word
// - while reset is low the executing instruction is abandoned
// - reset release: supervisor mode, masks set, full-width, reset vector
// - fast request pin is registered and only the copy is used
// - fast request tested at each instruction end when unmasked
// - fast interrupt entry sets both masks
// - normal request ranks below fast and is masked by it
// - normal request tested at each instruction end when unmasked
// - normal interrupt entry sets the normal mask
// - abort entries set the normal mask
// - fetch abort marks instruction; taken only at execute, dropped on flush
// - data abort sampled at the end of every data access
// - data abort restores the base register value
// - software trap enters supervisor mode with normal mask set
// - vector base from high-vector select except reset entry (always low base), offsets 0x00 to 0x1C
// - mode encodings for fast, normal, abort, undefined
// - fixed priority among simultaneous exceptions
`timescale 1ns/1ps
`include "exu_consts.svh"
module exu_core
  import exu_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // pins from the outside party
  input  wire logic        fast_request_low,
  input  wire logic        normal_request_low,
  input  wire logic        instruction_abort_input,
  input  wire logic        data_abort_input,
  input  wire logic        high_vector_select,
  // pipeline events
  input  wire logic        fetch_done,
  input  wire logic        issue,
  input  wire logic        flush,
  input  wire logic        data_done,
  input  wire logic        instr_end,
  input  wire logic [31:0] exec_pc,
  input  wire logic [31:0] next_pc,
  // decoded execute instruction
  input  wire logic        exec_is_trap,
  input  wire logic        exec_is_illegal,
  input  wire logic        exec_is_brk,
  input  wire logic        exec_is_mem,
  input  wire logic [3:0]  exec_base_idx,
  input  wire logic [31:0] exec_base_pre,
  // status writes
  input  wire logic        restore_req,
  input  wire logic        status_wr_en,
  input  wire logic [31:0] status_wr_data,
  // status outputs
  output logic [31:0]      current_status_word,
  output logic [31:0]      saved_status_word,
  output logic             core_abandon,
  // entry outputs
  output logic             fetch_redirect,
  output logic [31:0]      redirect_addr,
  output exu_kind_t        exc_kind,
  output logic             link_wr,
  output logic [31:0]      link_value,
  output logic [2:0]       link_bank,
  // base restore
  output logic             base_restore,
  output logic [3:0]       base_reg,
  output logic [31:0]      base_value
);
  exu_regs_t   q;
  exu_regs_t   d;
  logic [4:0]  pins_s;
  logic        fiq_low_s;
  logic        irq_low_s;
  logic        iabt_s;
  logic        dfa_s;
  logic        hv_s;
  logic        fiq_ok;
  logic        irq_ok;
  logic        take_now;
  exu_kind_t   kind_w;
  logic [31:0] link_w;
  logic [31:0] vec_w;
  logic [4:0]  mode_w;
  logic [2:0]  cur_bank;
  logic [2:0]  new_bank;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // request pins idle high so a reset never looks like a request
  exu_sync #(
    .W    (5),
    .RSTV (5'h03)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .din     ({high_vector_select, data_abort_input,
                instruction_abort_input, normal_request_low,
                fast_request_low}),
    .dout    (pins_s)
  );

  assign fiq_low_s = pins_s[0];
  assign irq_low_s = pins_s[1];
  assign iabt_s    = pins_s[2];
  assign dfa_s     = pins_s[3];
  assign hv_s      = pins_s[4];

  // ----------------------------------------
  // interrupt tests and priority
  // ----------------------------------------
  assign fiq_ok = !q.stat[`EXU_PSR_F] && !fiq_low_s;
  assign irq_ok = !q.stat[`EXU_PSR_I] && !irq_low_s;

  exu_entry_sel u_sel (
    .dfa     (q.dfa_pend),
    .fiq_ok  (fiq_ok),
    .irq_ok  (irq_ok),
    .pfa     (q.eabt),
    .brk     (exec_is_brk),
    .und     (exec_is_illegal),
    .trap    (exec_is_trap),
    .tbit    (q.stat[`EXU_PSR_T]),
    .hv      (hv_s),
    .exec_pc (exec_pc),
    .next_pc (next_pc),
    .kind    (kind_w),
    .link    (link_w),
    .vec     (vec_w)
  );

  assign mode_w   = exu_kind_mode(kind_w);
  assign cur_bank = exu_bank(q.stat[4:0]);
  assign new_bank = exu_bank(mode_w);
  // exceptions are only taken between instructions
  assign take_now = clk_en && q.st == EXU_ST_RUN && instr_end
                    && kind_w != EXU_K_NONE;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d      = q;
    d.ent  = 1'b0;
    d.lwr  = 1'b0;
    d.brst = 1'b0;
    case (q.st)
      EXU_ST_RST: begin
        d.abandon = 1'b0;
        d.stat     = `EXU_PSR_RST;
        d.fabt     = 1'b0;
        d.eabt     = 1'b0;
        d.dfa_pend = 1'b0;
        d.kind    = EXU_K_RST;
        d.vec     = vec_w;
        d.ent     = 1'b1;
        d.st      = EXU_ST_ENT;
      end
      EXU_ST_RUN, EXU_ST_ENT: begin
        if (q.st == EXU_ST_ENT) begin
          d.st = EXU_ST_RUN;
        end
        // abort flag travels with the fetched instruction
        if (issue) begin
          d.eabt = q.fabt;
        end
        if (flush) begin
          d.fabt = 1'b0;
        end
        if (fetch_done) begin
          d.fabt = iabt_s;
        end
        if (status_wr_en) begin
          d.stat = status_wr_data;
        end
        if (restore_req && cur_bank != `EXU_BANK_NONE) begin
          d.stat = q.saved[cur_bank];
        end
        if (take_now) begin
          d.saved[new_bank]       = q.stat;
          d.stat[4:0]             = mode_w;
          d.stat[`EXU_PSR_T]      = 1'b0;
          d.stat[`EXU_PSR_I]      = 1'b1;
          if (kind_w == EXU_K_FIQ) begin
            d.stat[`EXU_PSR_F] = 1'b1;
          end
          d.link  = link_w;
          d.lbank = new_bank;
          d.lwr   = 1'b1;
          d.vec   = vec_w;
          d.kind  = kind_w;
          d.ent   = 1'b1;
          d.st    = EXU_ST_ENT;
          d.fabt  = 1'b0;
          d.eabt  = 1'b0;
          if (kind_w == EXU_K_DFA) begin
            d.dfa_pend = 1'b0;
            d.brst = exec_is_mem;
            d.breg = exec_base_idx;
            d.bval = exec_base_pre;
          end
        end else if (instr_end && q.st == EXU_ST_RUN) begin
          // an instruction issued as the old one ends keeps its flag
          d.eabt = issue && q.fabt;
        end
        // a new abort in the clearing cycle survives
        if (data_done && dfa_s) begin
          d.dfa_pend = 1'b1;
        end
      end
      default: begin
        d.st = EXU_ST_RST;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q         <= '0;
      q.st      <= EXU_ST_RST;
      q.stat    <= `EXU_PSR_RST;
      q.abandon <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign current_status_word = q.stat;
  assign saved_status_word   = (cur_bank == `EXU_BANK_NONE) ? 32'h00000000 : q.saved[cur_bank];
  assign core_abandon        = q.abandon;
  assign fetch_redirect      = q.ent;
  assign redirect_addr       = q.vec;
  assign exc_kind            = q.kind;
  assign link_wr             = q.lwr;
  assign link_value          = q.link;
  assign link_bank           = q.lbank;
  assign base_restore        = q.brst;
  assign base_reg            = q.breg;
  assign base_value          = q.bval;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_LINK_COMPACT: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_TRAP && q.stat[`EXU_PSR_T]
    |=> link_value == $past(exec_pc) + 32'h00000002)
    else $error("compact trap link wrong");

  AST_LINK_FULL: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_UND && !q.stat[`EXU_PSR_T]
    |=> link_value == $past(exec_pc) + 32'h00000004)
    else $error("full-width undefined link wrong");

  AST_LINK_DFA: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_DFA
    |=> link_wr && link_value == $past(exec_pc) + 32'h00000008)
    else $error("data abort link wrong");

  AST_LINK_INT: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && (kind_w == EXU_K_IRQ || kind_w == EXU_K_FIQ)
    |=> link_value == $past(next_pc) + 32'h00000004)
    else $error("interrupt link wrong");

  AST_SAVE_PSR: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now |=> saved_status_word == $past(q.stat))
    else $error("status word not saved");

  AST_ENTRY_MODE: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now |=> fetch_redirect && !current_status_word[`EXU_PSR_T]
    && current_status_word[`EXU_PSR_I] && current_status_word[4:0] == $past(mode_w)
    && redirect_addr == $past(vec_w))
    else $error("entry mode or vector wrong");

  AST_FIQ_MASKS: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_FIQ
    |=> current_status_word[`EXU_PSR_F] && current_status_word[`EXU_PSR_I])
    else $error("fast entry masks not set");

  AST_PRIORITY: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && fiq_ok |-> kind_w == EXU_K_DFA || kind_w == EXU_K_FIQ)
    else $error("fast interrupt lost priority");

  AST_RESET_EXIT: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && q.st == EXU_ST_RST |=> current_status_word[7:0] == 8'hD3
    && fetch_redirect && redirect_addr[15:0] == 16'h0000 && !core_abandon)
    else $error("reset release wrong");

  AST_RESTORE: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && q.st == EXU_ST_RUN && restore_req && !take_now && cur_bank != `EXU_BANK_NONE
    |=> current_status_word == $past(saved_status_word))
    else $error("status not restored");

  AST_BASE_BACK: assert property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_DFA && exec_is_mem
    |=> base_restore && base_value == $past(exec_base_pre) ##1 !base_restore)
    else $error("base not restored");

  AST_FLUSH_DROP: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && flush && !fetch_done |=> !q.fabt)
    else $error("flushed abort kept");

  COV_FIQ: cover property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_FIQ);
  COV_DFA_MEM: cover property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_DFA && exec_is_mem);
  COV_TRAP_COMPACT: cover property (@(posedge clk_sys) disable iff (!resetn)
    take_now && kind_w == EXU_K_TRAP && q.stat[`EXU_PSR_T]);
  COV_RESTORE: cover property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && restore_req && q.st == EXU_ST_RUN);
endmodule

// ==== rtl/exu_entry_sel.sv ====
// exception priority, link value and vector address
`timescale 1ns/1ps
`include "exu_consts.svh"
module exu_entry_sel
  import exu_pkg::*;
(
  // pending causes
  input  wire logic        dfa,
  input  wire logic        fiq_ok,
  input  wire logic        irq_ok,
  input  wire logic        pfa,
  input  wire logic        brk,
  input  wire logic        und,
  input  wire logic        trap,
  // context
  input  wire logic        tbit,
  input  wire logic        hv,
  input  wire logic [31:0] exec_pc,
  input  wire logic [31:0] next_pc,
  // result
  output exu_kind_t        kind,
  output logic      [31:0] link,
  output logic      [31:0] vec
);
  logic [31:0] base;

  always_comb begin
    // fixed order: data abort first, traps last
    if (dfa)               kind = EXU_K_DFA;
    else if (fiq_ok)       kind = EXU_K_FIQ;
    else if (irq_ok)       kind = EXU_K_IRQ;
    else if (pfa || brk)   kind = EXU_K_PFA;
    else if (und)          kind = EXU_K_UND;
    else if (trap)         kind = EXU_K_TRAP;
    else                   kind = EXU_K_NONE;
  end

  always_comb begin
    case (kind)
      EXU_K_UND, EXU_K_TRAP: link = exec_pc + (tbit ? `EXU_LINK_2 : `EXU_LINK_4);
      EXU_K_DFA:             link = exec_pc + `EXU_LINK_8;
      EXU_K_PFA:             link = exec_pc + `EXU_LINK_4;
      EXU_K_IRQ, EXU_K_FIQ: link = next_pc + `EXU_LINK_4;
      default:              link = exec_pc;
    endcase
  end

  assign base = hv ? `EXU_VEC_HI : `EXU_VEC_LO;

  always_comb begin
    case (kind)
      EXU_K_UND:  vec = base + `EXU_OFS_UND;
      EXU_K_TRAP: vec = base + `EXU_OFS_TRAP;
      EXU_K_PFA:  vec = base + `EXU_OFS_PFA;
      EXU_K_DFA:  vec = base + `EXU_OFS_DFA;
      EXU_K_IRQ:  vec = base + `EXU_OFS_IRQ;
      EXU_K_FIQ:  vec = base + `EXU_OFS_FIQ;
      default:    vec = base + `EXU_OFS_RST;
    endcase
  end
endmodule

// ==== rtl/exu_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module exu_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RSTV;
      sync_q <= RSTV;
    end else if (clk_en) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ==== verification/cpu_exception_entry_exit_tb.sv ====
// self-checking bench of the exception entry and exit unit
`timescale 1ns/1ps
module cpu_exception_entry_exit_tb
  import exu_pkg::*;
;
  logic clk_sys = 1'b0, resetn = 1'b1, hv = 1'b0, clk_en = 1'b1;
  logic fiq_on = 1'b0, irq_on = 1'b0, iab_on = 1'b0, dab_on = 1'b0;
  logic frl, nrl, iai, dai;
  logic fetch_done = 1'b0, issue = 1'b0, flush = 1'b0, data_done = 1'b0, instr_end = 1'b0;
  logic [31:0] exec_pc = 32'h00000100, next_pc = 32'h00000200, base_pre = 32'h00000ABC, wr_data = '0;
  logic [2:0] dec = '0;
  logic is_mem = 1'b0, restore_req = 1'b0, wr_en = 1'b0;
  logic [31:0] csw, ssw, raddr, lval, bval, pre;
  logic abandon, redir, lwr, brst;
  logic [2:0] lbank;
  logic [3:0] breg;
  exu_kind_t kind;
  int err_total = 0, samples_checked = 0;

  always #50 clk_sys = ~clk_sys;

  exu_partner far_u (.fiq_on(fiq_on), .irq_on(irq_on), .iab_on(iab_on), .dab_on(dab_on),
    .fast_request_low(frl), .normal_request_low(nrl), .instruction_abort_input(iai), .data_abort_input(dai));

  exu_core dut_u (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .fast_request_low(frl), .normal_request_low(nrl), .instruction_abort_input(iai),
    .data_abort_input(dai), .high_vector_select(hv), .fetch_done(fetch_done), .issue(issue),
    .flush(flush), .data_done(data_done), .instr_end(instr_end), .exec_pc(exec_pc), .next_pc(next_pc),
    .exec_is_trap(dec[2]), .exec_is_illegal(dec[1]), .exec_is_brk(dec[0]), .exec_is_mem(is_mem),
    .exec_base_idx(4'h7), .exec_base_pre(base_pre), .restore_req(restore_req), .status_wr_en(wr_en),
    .status_wr_data(wr_data), .current_status_word(csw), .saved_status_word(ssw), .core_abandon(abandon),
    .fetch_redirect(redir), .redirect_addr(raddr), .exc_kind(kind), .link_wr(lwr), .link_value(lval),
    .link_bank(lbank), .base_restore(brst), .base_reg(breg), .base_value(bval));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic set_status(input logic [31:0] v);
    wr_data = v;
    wr_en   = 1'b1;
    step(1);
    wr_en = 1'b0;
    step(1);
    check("status write", csw, v);
  endtask

  // one instr_end pulse; outputs are looked at the cycle after
  task automatic pulse(input logic [2:0] d);
    dec       = d;
    instr_end = 1'b1;
    step(1);
    instr_end = 1'b0;
    dec       = '0;
  endtask

  task automatic entry(input logic [2:0] d, input exu_kind_t k, input logic [31:0] lnk,
                       input logic [31:0] vec, input logic [4:0] md, input logic [2:0] bk, input logic fset);
    pre = csw;
    pulse(d);
    check("redirect", redir, 32'h1);
    check("kind", kind, k);
    check("link write", lwr, 32'h1);
    check("link value", lval, lnk);
    check("link bank", lbank, bk);
    check("vector", raddr, vec);
    check("status", csw, {pre[31:8], 1'b1, fset | pre[6], 1'b0, md});
    check("saved status", ssw, pre);
    check("base restore", brst, {31'h0, k == EXU_K_DFA && is_mem});
    step(1);
    check("redirect ends", redir, 32'h0);
  endtask

  task automatic no_entry(input logic [2:0] d);
    pulse(d);
    check("no redirect", redir, 32'h0);
    step(1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    // a real falling edge on reset, so every flop is reset
    @(negedge clk_sys);
    resetn = 1'b0;
    step(20);
    check("abandon in reset", abandon, 32'h1);
    check("status in reset", csw, 32'h000000D3);
    resetn = 1'b1;
    step(1);
    check("reset redirect", redir, 32'h1);
    check("reset vector", raddr, 32'h00000000);
    check("reset kind", kind, EXU_K_RST);
    check("abandon released", abandon, 32'h0);
    check("no reset link", lwr, 32'h0);
    step(1);
    set_status(32'h00000030);
    entry(3'b100, EXU_K_TRAP, 32'h00000102, 32'h00000008, 5'h13, 3'h2, 1'b0);
    set_status(32'h00000010);
    entry(3'b010, EXU_K_UND, 32'h00000104, 32'h00000004, 5'h1B, 3'h4, 1'b0);
    set_status(32'h00000030);
    entry(3'b001, EXU_K_PFA, 32'h00000104, 32'h0000000C, 5'h17, 3'h3, 1'b0);
    // data abort pending while a trap decodes: abort must win
    set_status(32'h00000010);
    dab_on = 1'b1;
    step(3);
    data_done = 1'b1;
    step(1);
    data_done = 1'b0;
    dab_on    = 1'b0;
    is_mem    = 1'b1;
    entry(3'b100, EXU_K_DFA, 32'h00000108, 32'h00000010, 5'h17, 3'h3, 1'b0);
    check("base restore ends", brst, 32'h0);
    check("base reg", breg, 32'h7);
    check("base value", bval, 32'h00000ABC);
    is_mem = 1'b0;
    // fast and normal together with high vectors
    set_status(32'h00000010);
    fiq_on = 1'b1;
    irq_on = 1'b1;
    hv     = 1'b1;
    step(3);
    entry(3'b000, EXU_K_FIQ, 32'h00000204, 32'hFFFF001C, 5'h11, 3'h0, 1'b1);
    fiq_on = 1'b0;
    step(3);
    no_entry(3'b000);
    set_status(32'h00000010);
    entry(3'b000, EXU_K_IRQ, 32'h00000204, 32'hFFFF0018, 5'h12, 3'h1, 1'b0);
    restore_req = 1'b1;
    step(1);
    restore_req = 1'b0;
    check("restored status", csw, 32'h00000010);
    irq_on = 1'b0;
    hv     = 1'b0;
    fiq_on = 1'b1;
    set_status(32'h00000050);
    step(2);
    no_entry(3'b000);
    fiq_on = 1'b0;
    // fetch abort reaching execute, then one flushed first
    set_status(32'h00000010);
    iab_on = 1'b1;
    step(3);
    fetch_done = 1'b1;
    step(1);
    fetch_done = 1'b0;
    issue      = 1'b1;
    iab_on     = 1'b0;
    step(1);
    issue = 1'b0;
    entry(3'b000, EXU_K_PFA, 32'h00000104, 32'h0000000C, 5'h17, 3'h3, 1'b0);
    set_status(32'h00000010);
    iab_on = 1'b1;
    step(3);
    fetch_done = 1'b1;
    step(1);
    fetch_done = 1'b0;
    iab_on     = 1'b0;
    flush      = 1'b1;
    step(1);
    flush = 1'b0;
    issue = 1'b1;
    step(1);
    issue = 1'b0;
    no_entry(3'b000);
    // frozen clock enable: a trap at instruction end is not taken
    clk_en = 1'b0;
    no_entry(3'b100);
    clk_en = 1'b1;
    close_out();
  end

  // sequence needs some 90 cycles; 1500 cycles means a hang
  initial begin
    #150000;
    err_total++;
    close_out();
  end
endmodule

// ==== verification/exu_partner.sv ====
// model of the interrupt sources and the memory abort lines
`timescale 1ns/1ps
module exu_partner (
  // requests from the bench
  input  wire logic fiq_on,
  input  wire logic irq_on,
  input  wire logic iab_on,
  input  wire logic dab_on,
  // pins toward the core
  output logic      fast_request_low,
  output logic      normal_request_low,
  output logic      instruction_abort_input,
  output logic      data_abort_input
);
  // ----------------------------------------
  // levels held, not pulsed
  // ----------------------------------------
  // levels are held so the core's two-flop sampling always sees them settle
  assign fast_request_low        = ~fiq_on;
  assign normal_request_low      = ~irq_on;
  assign instruction_abort_input = iab_on;
  assign data_abort_input        = dab_on;
endmodule
